// ### rtl/sfw_watchdog.sv
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`include "sfw_map.svh"

module sfw_watchdog #(
	parameter int PRESCALE_CYC  = `SFW_PRESCALE_CYC,
	parameter int RST_PULSE_CYC = `SFW_RST_PULSE_CYC
) (
	// Clock and reset.
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Wishbone classic slave.
	input  wire logic       wb_cyc_i,
	input  wire logic       wb_stb_i,
	input  wire logic       wb_we_i,
	input  wire logic [7:0] wb_adr_i,
	input  wire logic [7:0] wb_dat_i,
	input  wire logic [0:0] wb_sel_i,
	output logic      [7:0] wb_dat_o,
	output logic            wb_ack_o,
	// Option settings and core events.
	input  wire logic       hw_watchdog_option_i,
	input  wire logic       sleep_no_reset_option_i,
	input  wire logic       sleep_exec_i,
	// Reset line to the chip reset controller.
	output logic            reset_n_o
);

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	localparam int PW = $clog2(PRESCALE_CYC);
	localparam int RW = $clog2(RST_PULSE_CYC + 1);
	localparam logic [7:0] CTRL_RESET = `SFW_CTRL_RESET;

	sfw_pkg::sfw_wb_req_t req;
	sfw_pkg::sfw_state_t  state;
	sfw_pkg::sfw_state_t  next_state;
	logic [PW-1:0]        presc;
	logic [PW-1:0]        next_presc;
	logic [6:0]           count;
	logic [6:0]           next_count;
	logic                 watchdog_arm_bit;
	logic                 next_arm;
	logic [RW-1:0]        pulse_cnt;
	logic [RW-1:0]        next_pulse_cnt;
	logic                 next_ack;
	logic [7:0]           next_dat;
	logic                 tick;
	logic                 armed;
	logic                 wr_ctrl;
	logic                 trigger;
	logic [RW-1:0]        low_cnt;
	logic [RW-1:0]        next_low_cnt;

	// Address decode shared by the write strobe and the read path.
	function automatic logic is_ctrl(input logic [7:0] adr);
		return adr == `SFW_CTRL_ADDR;
	endfunction

	// Bundle the bus request so the decode reads as one unit.
	assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
		dat: wb_dat_i};

	// Only a write with the single byte lane enabled lands in the register.
	// It lands at the edge that takes the request; the master still holds
	// the data until it sees the acknowledge one cycle later.
	assign wr_ctrl = req.cyc && req.stb && !wb_ack_o && req.we && wb_sel_i[0]
		&& is_ctrl(req.adr);

	// The prescaler is never cleared by software, which is why the timeout
	// carries up to one step of uncertainty.
	assign tick = (presc == PW'(PRESCALE_CYC - 1));

	// The hardware option overrides the arm bit entirely.
	assign armed = hw_watchdog_option_i || watchdog_arm_bit;

	// ------------------------------------------------------------------------
	// Reset triggers
	// ------------------------------------------------------------------------
	// Rollover past 40h, a software reset write, or a sleep while armed.
	// The software reset also fires under the hardware option, which arms it.
	always_comb begin
		trigger = 1'b0;
		if (armed && tick && !wr_ctrl && count == 7'h40) begin
			trigger = 1'b1;
		end
		if (wr_ctrl && (req.dat[`SFW_ARM_BIT] || hw_watchdog_option_i)
			&& !req.dat[`SFW_TOP_BIT]) begin
			trigger = 1'b1;
		end
		if (armed && sleep_exec_i && !sleep_no_reset_option_i) begin
			trigger = 1'b1;
		end
	end

	// ------------------------------------------------------------------------
	// Counter and control register
	// ------------------------------------------------------------------------
	// Next values of prescaler, count, arm bit and bus answer.
	always_comb begin
		next_presc = tick ? '0 : presc + PW'(1);
		next_count = count;
		next_arm   = watchdog_arm_bit;
		if (wr_ctrl) begin
			next_count = req.dat[`SFW_COUNT_MSB:0];
			next_arm   = watchdog_arm_bit | req.dat[`SFW_ARM_BIT];
		end else if (tick) begin
			next_count = count - 7'h01;
		end
		next_ack = req.cyc && req.stb && !wb_ack_o;
		next_dat = 8'h00;
		if (is_ctrl(req.adr)) begin
			next_dat = {watchdog_arm_bit, count};
		end
	end

	// Register the counter, control and bus state.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			presc            <= '0;
			count            <= CTRL_RESET[`SFW_COUNT_MSB:0];
			watchdog_arm_bit <= CTRL_RESET[`SFW_ARM_BIT];
			wb_ack_o         <= 1'b0;
			wb_dat_o         <= 8'h00;
		end else begin
			presc            <= next_presc;
			count            <= next_count;
			watchdog_arm_bit <= next_arm;
			wb_ack_o         <= next_ack;
			wb_dat_o         <= next_dat;
		end
	end

	// ------------------------------------------------------------------------
	// Reset pulse sequencer
	// ------------------------------------------------------------------------
	// The pulse is held for its full length; the chip reset that it causes
	// will also reset this block, so the pulse must be stretched externally
	// if the reset controller is held by it.
	// A trigger that comes while a pulse runs is dropped, not queued.
	always_comb begin
		next_state     = state;
		next_pulse_cnt = pulse_cnt;
		case (state)
			sfw_pkg::SFW_IDLE: begin
				if (trigger) begin
					next_state     = sfw_pkg::SFW_PULSE;
					next_pulse_cnt = RW'(RST_PULSE_CYC - 1);
				end
			end
			sfw_pkg::SFW_PULSE: begin
				if (pulse_cnt == '0) begin
					next_state = sfw_pkg::SFW_IDLE;
				end else begin
					next_pulse_cnt = pulse_cnt - RW'(1);
				end
			end
			default: begin
				next_state = sfw_pkg::SFW_IDLE;
			end
		endcase
	end

	// Register the sequencer.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state     <= sfw_pkg::SFW_IDLE;
			pulse_cnt <= '0;
		end else begin
			state     <= next_state;
			pulse_cnt <= next_pulse_cnt;
		end
	end

	// Reset line is low only while the pulse is running.
	assign reset_n_o = (state != sfw_pkg::SFW_PULSE);

	// Check helper: cycles spent low so far in the current pulse. It saves a
	// repetition of thousands of cycles in the pulse-length check.
	always_comb begin
		next_low_cnt = reset_n_o ? '0 : low_cnt + RW'(1);
	end

	// Register the check helper.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			low_cnt <= '0;
		end else begin
			low_cnt <= next_low_cnt;
		end
	end

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	// Every check is cut off by the synchronous reset except the reset-value
	// check, which watches the reset itself.
	chk_count_decrement: assert property (@(posedge clk_i) disable iff (rst_i)
		tick && !wr_ctrl |=> count == $past(count) - 7'h01)
		else $error("count did not decrement on tick");

	chk_count_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!tick && !wr_ctrl |=> $stable(count))
		else $error("count changed without tick or write");

	chk_rollover_reset: assert property (@(posedge clk_i) disable iff (rst_i)
		armed && tick && !wr_ctrl && count == 7'h40 && state == sfw_pkg::SFW_IDLE
		|=> !reset_n_o)
		else $error("rollover did not start reset");

	chk_pulse_length: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(reset_n_o) |-> !reset_n_o [*8])
		else $error("reset pulse too short");

	chk_arm_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		watchdog_arm_bit |=> watchdog_arm_bit)
		else $error("arm bit cleared without reset");

	chk_soft_reset: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctrl && wb_dat_i[7] && !wb_dat_i[6] && state == sfw_pkg::SFW_IDLE
		|=> !reset_n_o)
		else $error("software reset write ignored");

	chk_sleep_reset: assert property (@(posedge clk_i) disable iff (rst_i)
		armed && sleep_exec_i && !sleep_no_reset_option_i && reset_n_o
		|=> !reset_n_o)
		else $error("sleep while armed did not reset");

	chk_unarmed_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		!hw_watchdog_option_i && !watchdog_arm_bit && !wr_ctrl && reset_n_o
		|=> reset_n_o)
		else $error("reset raised while disarmed");

	chk_write_load: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctrl |=> count == $past(wb_dat_i[6:0]))
		else $error("write did not load count");

	chk_read_data: assert property (@(posedge clk_i) disable iff (rst_i)
		req.cyc && req.stb && !wb_ack_o && req.adr == 8'h33
		|=> wb_dat_o == {$past(watchdog_arm_bit), $past(count)})
		else $error("read data wrong");

	chk_unmapped_read: assert property (@(posedge clk_i) disable iff (rst_i)
		req.cyc && req.stb && !wb_ack_o && !is_ctrl(req.adr)
		|=> wb_dat_o == 8'h00)
		else $error("unmapped read returned data");

	chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge held longer than one cycle");

	chk_reset_value: assert property (@(posedge clk_i)
		rst_i |=> count == 7'h7F && !watchdog_arm_bit && reset_n_o)
		else $error("register not at its reset value after reset");

	chk_count_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
		tick && !wr_ctrl && count == 7'h00 |=> count == 7'h7F)
		else $error("count did not wrap from zero");

	chk_presc_free: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctrl && !tick |=> presc == $past(presc) + PW'(1))
		else $error("register write disturbed the prescaler");

	chk_arm_set: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctrl && wb_dat_i[7] |=> watchdog_arm_bit)
		else $error("arm bit not set by write");

	chk_pulse_exact: assert property (@(posedge clk_i) disable iff (rst_i)
		reset_n_o && !$past(reset_n_o) |-> low_cnt == RW'(RST_PULSE_CYC))
		else $error("reset pulse length wrong");

	chk_pulse_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!reset_n_o && pulse_cnt != '0 |=> !reset_n_o)
		else $error("reset pulse ended early");

	chk_hw_rollover: assert property (@(posedge clk_i) disable iff (rst_i)
		hw_watchdog_option_i && !watchdog_arm_bit && tick && !wr_ctrl
		&& count == 7'h40 && reset_n_o |=> !reset_n_o)
		else $error("hardware option did not arm the rollover reset");

	chk_hw_soft_reset: assert property (@(posedge clk_i) disable iff (rst_i)
		hw_watchdog_option_i && wr_ctrl && !wb_dat_i[6] && reset_n_o
		|=> !reset_n_o)
		else $error("hardware option did not arm the software reset");

	chk_sleep_option: assert property (@(posedge clk_i) disable iff (rst_i)
		sleep_exec_i && sleep_no_reset_option_i && !wr_ctrl && !tick && reset_n_o
		|=> reset_n_o)
		else $error("sleep reset despite the no-reset option");

endmodule // sfw_watchdog

// ### rtl/sfw_map.svh
`ifndef SFW_MAP_SVH
`define SFW_MAP_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define SFW_CTRL_ADDR      8'h33
`define SFW_CTRL_RESET     8'h7F
`define SFW_ARM_BIT        7
`define SFW_TOP_BIT        6
`define SFW_COUNT_MSB      6

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SFW_PRESCALE_CYC   16000
`define SFW_CLK_MHZ        100
`define SFW_RST_PULSE_US   30
`define SFW_RST_PULSE_CYC  (`SFW_RST_PULSE_US * `SFW_CLK_MHZ)

`endif

// ### rtl/sfw_pkg.sv
package sfw_pkg;

	// One Wishbone classic slave request.
	typedef struct packed {
		logic       cyc;
		logic       stb;
		logic       we;
		logic [7:0] adr;
		logic [7:0] dat;
	} sfw_wb_req_t;

	// Reset cycle sequencer states.
	typedef enum logic [1:0] {
		SFW_IDLE  = 2'b01,
		SFW_PULSE = 2'b10
	} sfw_state_t;

endpackage

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	localparam int PSC = 4;
	localparam int PUL = 10;
	// -------------------------------------------------------------
	// Bench signals
	// -------------------------------------------------------------
	logic       clk_i, rst_i, cyc, we, hw, nosl, slp, ack, rst_n;
	logic [7:0] adr, wdat, rdat, q, v;
	logic [31:0] lf = 32'h1CEDD85E;
	int         mismatches, n_checks, np, run, len;

	sfw_watchdog #(.PRESCALE_CYC(PSC), .RST_PULSE_CYC(PUL)) u_sfw_watchdog (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(1'b1), .wb_dat_o(rdat), .wb_ack_o(ack),
		.hw_watchdog_option_i(hw), .sleep_no_reset_option_i(nosl), .sleep_exec_i(slp),
		.reset_n_o(rst_n));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// Counts reset pulses and keeps the length of the last one.
	always @(posedge clk_i) begin
		if (rst_i) begin
			np <= 0;
			run <= 0;
		end else if (rst_n === 1'b0) begin
			run <= run + 1;
		end else if (run > 0) begin
			np <= np + 1;
			len <= run;
			run <= 0;
		end
	end

	// -------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Free-running count may tick between write and read, so a window is accepted.
	function automatic logic [7:0] pick(input logic [7:0] got, hi, lo);
		return (got <= hi && got >= lo) ? got : hi;
	endfunction

	task automatic check(input string what, input logic [7:0] exp, got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Classic single cycle; the request holds until ack is sampled high.
	task automatic bus(input logic w, input logic [7:0] a, d);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic pulses(input int n, input int exp);
		repeat (n) @(posedge clk_i);
		check("pulses", 8'(exp), 8'(np));
		if (exp > 0) check("pulse_len", 8'(PUL), 8'(len));
	endtask

	task automatic do_reset();
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// A hang costs one mismatch and ends the run the normal way.
	initial begin
		#200000;
		mismatches++;
		wrap_up();
	end

	// -------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------
	initial begin
		{cyc, we, hw, nosl, slp, adr, wdat} = '0;
		rst_i = 1'b1;
		do_reset();
		bus(0, 8'h33, 8'h00);
		check("reset_value", 8'h7F, q);
		bus(0, 8'h34, 8'h00);
		check("unmapped", 8'h00, q);
		for (int i = 0; i < 8; i++) begin
			lf = lfsr(lf);
			v = {2'b01, lf[5:0]};
			bus(1, 8'h33, v);
			bus(0, 8'h33, 8'h00);
			check("readback", pick(q, v, v - 8'h01), q);
		end
		bus(1, 8'h33, 8'h42);
		repeat (40) @(posedge clk_i);
		bus(0, 8'h33, 8'h00);
		check("count", pick(q, 8'h38, 8'h37), q);
		pulses(2, 0);
		bus(1, 8'h33, 8'hC2);
		pulses(3 * PSC + PUL + 8, 1);
		bus(1, 8'h33, 8'h7F);
		check("arm_kept", 8'h01, {7'h00, q[7]});
		bus(0, 8'h33, 8'h00);
		check("arm_kept", 8'h01, {7'h00, q[7]});
		do_reset();
		bus(0, 8'h33, 8'h00);
		check("arm_clear", 8'h00, {7'h00, q[7]});
		bus(1, 8'h33, 8'h00);
		pulses(20, 0);
		bus(1, 8'h33, 8'h80);
		pulses(20, 1);
		do_reset();
		slp <= 1'b1;
		@(posedge clk_i);
		slp <= 1'b0;
		pulses(20, 0);
		bus(1, 8'h33, 8'hFF);
		nosl <= 1'b1;
		slp <= 1'b1;
		@(posedge clk_i);
		slp <= 1'b0;
		pulses(20, 0);
		nosl <= 1'b0;
		slp <= 1'b1;
		@(posedge clk_i);
		slp <= 1'b0;
		pulses(20, 1);
		do_reset();
		hw <= 1'b1;
		bus(1, 8'h33, 8'h42);
		pulses(3 * PSC + PUL + 8, 1);
		bus(1, 8'h33, 8'h00);
		pulses(20, 2);
		wrap_up();
	end
endmodule // tb_top
